// >>> rtl/ssc_pkg.sv
// Shared constants and carriers for the start source select block.
// Assumes a single 125 MHz clock domain and a plain register port.
package ssc_pkg;

  // Register offsets (word addresses on the plain port)
  localparam logic [3:0] SSC_CFG_OFS = 4'h0;
  localparam logic [3:0] SSC_CTRL_OFS = 4'h1;
  localparam logic [3:0] SSC_THERM_OFS = 4'h2;
  localparam logic [3:0] SSC_STAT_OFS = 4'h3;
  localparam logic [3:0] SSC_INT_STAT_OFS = 4'h4;
  localparam logic [3:0] SSC_INT_MASK_OFS = 4'h5;

  // Field positions in the configuration register
  localparam int SSC_RUN_CLASS_POS = 0;
  localparam int SSC_START_CLASS_POS = 8;
  localparam int SSC_LOC_SRC_POS = 16;
  localparam int SSC_REM_SRC_POS = 18;
  localparam int SSC_SEP_EN_POS = 20;
  localparam int SSC_KSTOP_DIS_POS = 21;
  localparam int SSC_LR_PIN_EN_POS = 22;

  // Control register bit
  localparam int SSC_LR_BIT_POS = 0;

  // Overload class and thermal limits; class zero encodes Off
  localparam logic [7:0] SSC_CLASS_OFF = 8'h00;
  localparam logic [7:0] SSC_CLASS_MAX = 8'h28;
  localparam logic [7:0] SSC_CLASS_RST = 8'h0A;
  localparam logic [6:0] SSC_THERM_MAX = 7'h64;
  localparam logic [6:0] SSC_THERM_RST = 7'h00;

  // Interrupt event bits
  localparam int SSC_EV_START = 0;
  localparam int SSC_EV_STOP = 1;
  localparam int SSC_EV_TRIP = 2;
  localparam int SSC_EV_SRC = 3;
  localparam int SSC_EV_W = 4;

  // Command source encodings
  typedef enum logic [1:0] {
    SSC_SRC_KEYPAD = 2'b00,
    SSC_SRC_TERMINAL = 2'b01,
    SSC_SRC_NETWORK = 2'b10
  } ssc_src_type;

  // Start and stop request pair from one source
  typedef struct packed {
    logic start;
    logic stop;
  } ssc_cmd_type;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ssc_bus_type;

endpackage : ssc_pkg

// >>> rtl/ssc_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module ssc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Only the second stage reads the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : ssc_sync

// >>> rtl/ssc_top.sv
// Control source selection and overload class configuration.
// Assumes pins are asynchronous; register port is on REF_CLK.
// How it works
// - Running class Off or 1..40, reset 10
// - Separate starting class only when option on
// - Thermal value held as 0..100 percent
// - Class Off disables overload in all states
// - Keypad source routes keypad start/stop
// - Terminal source uses terminal inputs, reset default
// - Network source uses serial link commands
// - Configured local/remote input picks active setting
// - Low picks local, high picks remote
// - Without input, control register bit decides
// - Local/remote bit resets to zero, local
// - Keypad stop always stops by default
// - Keypad stop disable ignores keypad stop unless keypad is the active source
// - Remote setting same encodings, terminal default
`timescale 1ns/1ps
module ssc_top
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Keypad commands (pins)
  input wire logic KEY_START,
  input wire logic KEY_STOP,
  // Terminal strip commands (pins)
  input wire logic TERM_START,
  input wire logic TERM_STOP,
  // Local/remote digital input level (pin)
  input wire logic LR_IN,
  // Network commands, same clock, held as levels
  input wire logic NET_START,
  input wire logic NET_STOP,
  // Thermal model update, same clock
  input wire logic THERM_WR,
  input wire logic [6:0] THERM_IN,
  // Outputs to starter control
  output logic START_CMD,
  output logic STOP_CMD,
  output logic OL_ENABLE,
  output logic [7:0] OL_CLASS,
  output logic OL_TRIPPED,
  output logic [6:0] THERM_PCT,
  output logic REMOTE_ACTIVE,
  output logic IRQ
);

  // Synchronised pin levels
  logic [4:0] pins_s;
  ssc_cmd_type key_cmd;
  ssc_cmd_type term_cmd;
  ssc_cmd_type net_cmd;
  logic lr_pin;

  ssc_sync #(
    .W(5)
  ) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d({KEY_START, KEY_STOP, TERM_START, TERM_STOP, LR_IN}),
    .q(pins_s)
  );

  // Pin commands arrive two edges after the network ones; anything
  // that compares sources must allow for that skew
  assign key_cmd = ssc_cmd_type'(pins_s[4:3]);
  assign term_cmd = ssc_cmd_type'(pins_s[2:1]);
  assign lr_pin = pins_s[0];
  assign net_cmd = '{start: NET_START, stop: NET_STOP};

  // Configuration state
  logic [7:0] run_class_r;
  logic [7:0] start_class_r;
  ssc_src_type loc_src_r;
  ssc_src_type rem_src_r;
  logic sep_en_r;
  logic kstop_dis_r;
  logic lr_pin_en_r;
  logic lr_bit_r;
  logic [6:0] therm_r;
  logic [SSC_EV_W-1:0] int_stat_r;
  logic [SSC_EV_W-1:0] int_mask_r;
  logic starting_r;
  logic running_r;

  // Decoded bus fields
  ssc_bus_type bus;
  logic cfg_wr;
  logic ctrl_wr;
  logic therm_wr_sw;
  logic stat_wr;
  logic mask_wr;
  logic [7:0] w_run;
  logic [7:0] w_start;
  logic [1:0] w_loc;
  logic [1:0] w_rem;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign w_run = bus.wdata[SSC_RUN_CLASS_POS +: 8];
  assign w_start = bus.wdata[SSC_START_CLASS_POS +: 8];
  assign w_loc = bus.wdata[SSC_LOC_SRC_POS +: 2];
  assign w_rem = bus.wdata[SSC_REM_SRC_POS +: 2];

  // Write decode
  always_comb begin
    cfg_wr = 1'b0;
    ctrl_wr = 1'b0;
    therm_wr_sw = 1'b0;
    stat_wr = 1'b0;
    mask_wr = 1'b0;
    if (bus.wr && bus.addr == SSC_CFG_OFS) begin
      cfg_wr = 1'b1;
    end else if (bus.wr && bus.addr == SSC_CTRL_OFS) begin
      ctrl_wr = 1'b1;
    end else if (bus.wr && bus.addr == SSC_THERM_OFS) begin
      therm_wr_sw = 1'b1;
    end else if (bus.wr && bus.addr == SSC_INT_STAT_OFS) begin
      stat_wr = 1'b1;
    end else if (bus.wr && bus.addr == SSC_INT_MASK_OFS) begin
      mask_wr = 1'b1;
    end
  end

  // Overload classes; out-of-range writes keep the old value
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_class_r <= SSC_CLASS_RST;
      start_class_r <= SSC_CLASS_RST;
      sep_en_r <= 1'b0;
    end else if (cfg_wr) begin
      if (w_run <= SSC_CLASS_MAX) begin
        run_class_r <= w_run;
      end
      if (w_start <= SSC_CLASS_MAX) begin
        start_class_r <= w_start;
      end
      sep_en_r <= bus.wdata[SSC_SEP_EN_POS];
    end
  end

  // Source settings; the unused fourth code is refused
  // Keeping the old code avoids routing commands from no source
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      loc_src_r <= SSC_SRC_TERMINAL;
      rem_src_r <= SSC_SRC_TERMINAL;
      kstop_dis_r <= 1'b0;
      lr_pin_en_r <= 1'b0;
    end else if (cfg_wr) begin
      if (w_loc != 2'h3) begin
        loc_src_r <= ssc_src_type'(w_loc);
      end
      if (w_rem != 2'h3) begin
        rem_src_r <= ssc_src_type'(w_rem);
      end
      kstop_dis_r <= bus.wdata[SSC_KSTOP_DIS_POS];
      lr_pin_en_r <= bus.wdata[SSC_LR_PIN_EN_POS];
    end
  end

  // Network starter control local/remote bit
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lr_bit_r <= 1'b0;
    end else if (ctrl_wr) begin
      lr_bit_r <= bus.wdata[SSC_LR_BIT_POS];
    end
  end

  // Thermal value, saturated at 100; model input wins over software
  // Clamped rather than refused, since the model may overshoot
  logic [6:0] therm_nxt;
  always_comb begin
    therm_nxt = therm_r;
    if (THERM_WR) begin
      therm_nxt = THERM_IN;
    end else if (therm_wr_sw) begin
      therm_nxt = bus.wdata[6:0];
    end
    if (therm_nxt > SSC_THERM_MAX) begin
      therm_nxt = SSC_THERM_MAX;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      therm_r <= SSC_THERM_RST;
    end else begin
      therm_r <= therm_nxt;
    end
  end

  // Active source selection, combinational so it acts next cycle
  logic remote_sel;
  ssc_src_type act_src;
  ssc_cmd_type sel_cmd;
  always_comb begin
    remote_sel = lr_pin_en_r ? lr_pin : lr_bit_r;
    act_src = remote_sel ? rem_src_r : loc_src_r;
    sel_cmd = '0;
    case (act_src)
      SSC_SRC_KEYPAD: sel_cmd = key_cmd;
      SSC_SRC_TERMINAL: sel_cmd = term_cmd;
      SSC_SRC_NETWORK: sel_cmd = net_cmd;
      default: sel_cmd = '0;
    endcase
  end

  // Keypad stop acts from any source unless disabled
  logic stop_nxt;
  logic start_nxt;
  assign stop_nxt = sel_cmd.stop | (key_cmd.stop & ~kstop_dis_r);
  assign start_nxt = sel_cmd.start & ~stop_nxt;

  // Simple motor state for class choice; stop has priority
  // Limitation: the start level alone advances it, no ramp feedback
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      starting_r <= 1'b0;
      running_r <= 1'b0;
    end else if (stop_nxt || OL_TRIPPED) begin
      starting_r <= 1'b0;
      running_r <= 1'b0;
    end else if (start_nxt && !starting_r && !running_r) begin
      starting_r <= 1'b1;
    end else if (starting_r && !sel_cmd.start) begin
      starting_r <= 1'b0;
      running_r <= 1'b1;
    end
  end

  // Class applied: starting class only with separate option on
  logic [7:0] class_nxt;
  always_comb begin
    if (run_class_r == SSC_CLASS_OFF) begin
      class_nxt = SSC_CLASS_OFF;
    end else if (sep_en_r && starting_r) begin
      class_nxt = start_class_r;
    end else begin
      class_nxt = run_class_r;
    end
  end

  // Trip follows the class actually applied, so an Off starting
  // class never reports a trip while protection is disabled
  logic trip_nxt;
  assign trip_nxt = (class_nxt != SSC_CLASS_OFF)
                    && (therm_nxt == SSC_THERM_MAX);

  // Registered outputs
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      START_CMD <= 1'b0;
      STOP_CMD <= 1'b0;
      OL_ENABLE <= 1'b1;
      OL_CLASS <= SSC_CLASS_RST;
      OL_TRIPPED <= 1'b0;
      THERM_PCT <= SSC_THERM_RST;
      REMOTE_ACTIVE <= 1'b0;
    end else begin
      START_CMD <= start_nxt;
      STOP_CMD <= stop_nxt;
      OL_ENABLE <= class_nxt != SSC_CLASS_OFF;
      OL_CLASS <= class_nxt;
      OL_TRIPPED <= trip_nxt;
      THERM_PCT <= therm_nxt;
      REMOTE_ACTIVE <= remote_sel;
    end
  end

  // Interrupt events; set wins over write-one-to-clear
  logic [SSC_EV_W-1:0] ev;
  logic remote_d_r;
  always_comb begin
    ev = '0;
    ev[SSC_EV_START] = start_nxt;
    ev[SSC_EV_STOP] = stop_nxt;
    ev[SSC_EV_TRIP] = trip_nxt && !OL_TRIPPED;
    ev[SSC_EV_SRC] = remote_sel ^ remote_d_r;
  end

  // Per-bit sticky status; a set in the clearing cycle survives
  wire logic [SSC_EV_W-1:0] int_stat_nxt;
  for (genvar g = 0; g < SSC_EV_W; g++) begin : g_stat
    assign int_stat_nxt[g] = (int_stat_r[g] & ~(stat_wr & bus.wdata[g]))
                             | ev[g];
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      remote_d_r <= 1'b0;
      int_stat_r <= '0;
      int_mask_r <= '0;
      IRQ <= 1'b0;
    end else begin
      remote_d_r <= remote_sel;
      int_stat_r <= int_stat_nxt;
      if (mask_wr) begin
        int_mask_r <= bus.wdata[SSC_EV_W-1:0];
      end
      IRQ <= |(int_stat_r & int_mask_r);
    end
  end

  // Read decode; unmapped or idle cycles give zero
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = '0;
    if (bus.rd && bus.addr == SSC_CFG_OFS) begin
      rdata_nxt = {9'h0, lr_pin_en_r, kstop_dis_r, sep_en_r,
                   rem_src_r, loc_src_r, start_class_r, run_class_r};
    end else if (bus.rd && bus.addr == SSC_CTRL_OFS) begin
      rdata_nxt = {31'h0, lr_bit_r};
    end else if (bus.rd && bus.addr == SSC_THERM_OFS) begin
      rdata_nxt = {25'h0, therm_r};
    end else if (bus.rd && bus.addr == SSC_STAT_OFS) begin
      rdata_nxt = {26'h0, OL_TRIPPED, OL_ENABLE, running_r,
                   starting_r, act_src};
    end else if (bus.rd && bus.addr == SSC_INT_STAT_OFS) begin
      rdata_nxt = {28'h0, int_stat_r};
    end else if (bus.rd && bus.addr == SSC_INT_MASK_OFS) begin
      rdata_nxt = {28'h0, int_mask_r};
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else begin
      RDATA <= rdata_nxt;
    end
  end

endmodule : ssc_top

// >>> test/ssc_properties.sv
// Checker on the outputs of the start source select block.
// Assumes it is bound to ssc_top and sees only its ports.
`timescale 1ns/1ps
module ssc_props
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Watched ports
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic START_CMD,
  input wire logic OL_ENABLE,
  input wire logic [7:0] OL_CLASS,
  input wire logic OL_TRIPPED,
  input wire logic [6:0] THERM_PCT,
  input wire logic REMOTE_ACTIVE,
  input wire logic IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Defaults seen at the first edge after release
  chk_reset_class:
    assert property ($rose(RST_N) |-> OL_CLASS == SSC_CLASS_RST)
    else $error("class not default after reset");
  chk_reset_local:
    assert property ($rose(RST_N) |-> !REMOTE_ACTIVE && !START_CMD)
    else $error("remote or start after reset");
  // Ranges of held values
  chk_class_max:
    assert property (OL_CLASS <= SSC_CLASS_MAX)
    else $error("class above limit");
  chk_therm_max:
    assert property (THERM_PCT <= SSC_THERM_MAX)
    else $error("thermal above full");
  // Off means no protection at all
  chk_off_class:
    assert property (!OL_ENABLE |-> OL_CLASS == SSC_CLASS_OFF)
    else $error("disabled with a class applied");
  chk_trip_enable:
    assert property (OL_TRIPPED |-> OL_ENABLE)
    else $error("trip while protection off");
  // A trip needs the value at full, now or one edge ago
  chk_trip_full:
    assert property ($rose(OL_TRIPPED) |->
      THERM_PCT == SSC_THERM_MAX || $past(THERM_PCT) == SSC_THERM_MAX)
    else $error("trip below full");
  // Read data only stand after a read strobe
  chk_rdata_idle:
    assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("read data without read");
  cover property (START_CMD);
  cover property (REMOTE_ACTIVE);
  cover property (OL_TRIPPED);
  cover property (IRQ);
endmodule : ssc_props

// >>> test/ssc_far.sv
// Far side model: keypad, terminal strip and network master.
// Assumes requests arrive as levels just after a rising edge.
`timescale 1ns/1ps
module ssc_far
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire ssc_cmd_type key_req,
  input wire ssc_cmd_type term_req,
  input wire ssc_cmd_type net_req,
  // Lines into the block
  output ssc_cmd_type key_pin,
  output ssc_cmd_type term_pin,
  output ssc_cmd_type net_line
);
  // Lines lag one edge, so pins are never released on the bench edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {key_pin, term_pin, net_line} <= 6'h0;
    end else begin
      {key_pin, term_pin, net_line} <= {key_req, term_req, net_req};
    end
  end
endmodule : ssc_far

// >>> test/tb.sv
// Self-checking bench for the start source select block.
// Assumes ssc_pkg, ssc_top, ssc_far and ssc_props are compiled.
`timescale 1ns/1ps
module tb
  import ssc_pkg::*;
;
  logic clk, rst_n, wr, rd, lr, twr, st, sp, ole, olt, rem, irq;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [6:0] tin, tpct;
  logic [7:0] olc;
  ssc_cmd_type kq, tq, nq, kp, tp, np;
  int miscompares = 0;
  int checked = 0;
  int i, j;
  // Block and its far side
  ssc_far FAR (.clk(clk), .rst_n(rst_n), .key_req(kq), .term_req(tq),
    .net_req(nq), .key_pin(kp), .term_pin(tp), .net_line(np));
  ssc_top DUT (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .KEY_START(kp.start),
    .KEY_STOP(kp.stop), .TERM_START(tp.start), .TERM_STOP(tp.stop),
    .LR_IN(lr), .NET_START(np.start), .NET_STOP(np.stop),
    .THERM_WR(twr), .THERM_IN(tin), .START_CMD(st), .STOP_CMD(sp),
    .OL_ENABLE(ole), .OL_CLASS(olc), .OL_TRIPPED(olt), .THERM_PCT(tpct),
    .REMOTE_ACTIVE(rem), .IRQ(irq));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Register port: one-cycle strobes, a gap edge keeps drivers clean
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : rreg
  // Commands pass partner, sync and output flop: wait past that
  task automatic put(input ssc_cmd_type k, t, n);
    kq <= k;
    tq <= t;
    nq <= n;
    cyc(6);
  endtask : put
  task automatic therm(input logic [6:0] v);
    tin <= v;
    twr <= 1'b1;
    @(posedge clk);
    twr <= 1'b0;
    cyc(3);
  endtask : therm
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  function automatic logic [31:0] cfg(input logic [7:0] rc, sc,
      input logic [1:0] ls, rs, input logic sep, kd, lp);
    return {9'h0, lp, kd, sep, rs, ls, sc, rc};
  endfunction : cfg
  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {wr, rd, lr, twr} = 4'h0;
    {addr, wdata, tin} = 43'h0;
    {kq, tq, nq} = 6'h0;
    void'($urandom(82122));
    cyc(3);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(SSC_CFG_OFS, got);
    cmp(got, cfg(SSC_CLASS_RST, SSC_CLASS_RST, 1, 1, 0, 0, 0));
    cmp(olc, SSC_CLASS_RST);
    rreg(SSC_CTRL_OFS, got);
    cmp(got, 0);
    rreg(4'hF, got);
    cmp(got, 0);
    // Legal classes, then an over-range write that must be refused
    for (i = 0; i < 4; i++) begin
      j = (i == 0) ? 40 : 1 + $urandom % 40;
      wreg(SSC_CFG_OFS, cfg(j[7:0], 8'h0A, 1, 1, 0, 0, 0));
      wreg(SSC_CFG_OFS, cfg(8'h29, 8'h0A, 1, 1, 0, 0, 0));
      cyc(3);
      cmp(olc, j);
      cmp(ole, 1);
    end
    wreg(SSC_CFG_OFS, cfg(SSC_CLASS_OFF, 8'h0A, 1, 1, 0, 0, 0));
    therm(7'h64);
    cmp({ole, olc}, 0);
    cmp({olt, tpct}, 8'h64);
    wreg(SSC_CFG_OFS, cfg(8'h0A, 8'h0A, 1, 1, 0, 0, 0));
    cyc(3);
    cmp(olt, 1);
    therm(7'h78);
    cmp(tpct, 7'h64);
    j = $urandom % 100;
    wreg(SSC_THERM_OFS, j);
    rreg(SSC_THERM_OFS, got);
    cmp(got, j);
    // Every local source against a start from every source
    for (i = 0; i < 3; i++) begin
      wreg(SSC_CFG_OFS, cfg(8'h0A, 8'h0A, i[1:0], 1, 0, 0, 0));
      rreg(SSC_STAT_OFS, got);
      cmp(got[1:0], i);
      for (j = 0; j < 3; j++) begin
        put({j == 0, 1'b0}, {j == 1, 1'b0}, {j == 2, 1'b0});
        cmp(st, i == j);
      end
      put(0, 0, 0);
      put(2'b01, 0, 0);
      cmp(sp, 1);
      wreg(SSC_CFG_OFS, cfg(8'h0A, 8'h0A, i[1:0], 1, 0, 1, 0));
      // Output flop shows the new setting one edge after the write
      cyc(1);
      cmp(sp, i == 0);
      put(0, 0, 0);
    end
    // Input picks the setting; without it the control bit does
    wreg(SSC_CFG_OFS, cfg(8'h0A, 8'h0A, 0, 2, 0, 0, 1));
    lr <= 1'b1;
    put(0, 0, 2'b10);
    cmp({rem, st}, 2'b11);
    lr <= 1'b0;
    put(0, 0, 2'b10);
    cmp({rem, st}, 2'b00);
    wreg(SSC_CFG_OFS, cfg(8'h0A, 8'h0A, 0, 2, 0, 0, 0));
    wreg(SSC_CTRL_OFS, 1);
    put(0, 0, 2'b10);
    cmp({rem, st}, 2'b11);
    lr <= 1'b1;
    wreg(SSC_CTRL_OFS, 0);
    put(0, 0, 0);
    cmp(rem, 0);
    // Separate starting class only while the option is on
    for (i = 1; i >= 0; i--) begin
      j = 1 + $urandom % 40;
      wreg(SSC_CFG_OFS, cfg(j[7:0], 8'h14, 2, 2, i[0], 0, 0));
      put(0, 0, 2'b01);
      put(0, 0, 2'b10);
      cmp(olc, i ? 8'h14 : j);
      put(0, 0, 0);
      cmp(olc, j);
    end
    // Interrupt: raise, mask, unmask, clear
    put(0, 0, 2'b01);
    wreg(SSC_INT_STAT_OFS, 32'h0000_000F);
    wreg(SSC_INT_MASK_OFS, 32'h0000_0001);
    cyc(1);
    cmp(irq, 0);
    put(0, 0, 2'b10);
    cmp(irq, 1);
    put(0, 0, 0);
    // IRQ is registered from the mask, so it trails a write by an edge
    wreg(SSC_INT_MASK_OFS, 0);
    cyc(1);
    cmp(irq, 0);
    wreg(SSC_INT_MASK_OFS, 32'h0000_0001);
    cyc(1);
    cmp(irq, 1);
    wreg(SSC_INT_STAT_OFS, 32'h0000_0001);
    cyc(1);
    cmp(irq, 0);
    summarize();
  end
endmodule : tb
bind ssc_top ssc_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .RD(RD), .RDATA(RDATA), .START_CMD(START_CMD), .OL_ENABLE(OL_ENABLE),
  .OL_CLASS(OL_CLASS), .OL_TRIPPED(OL_TRIPPED), .THERM_PCT(THERM_PCT),
  .REMOTE_ACTIVE(REMOTE_ACTIVE), .IRQ(IRQ));
